// ---- pkg/scm_clk_if.sv ----
// signals between the mode controller and the clock selector
// assumes both ends share pclk
`timescale 1ns/100ps
interface scm_clk_if;
  logic fast_tick;
  logic slow_tick;
  logic fast_on;
  logic sel_fast;
  logic [2:0] div;
  logic force_sub;
  logic sys_tick;
  logic div16_tick;
  logic div64_tick;
  modport ctrl (
    output fast_tick, slow_tick, fast_on, sel_fast, div, force_sub,
    input sys_tick, div16_tick, div64_tick
  );
  modport sel (
    input fast_tick, slow_tick, fast_on, sel_fast, div, force_sub,
    output sys_tick, div16_tick, div64_tick
  );
endinterface : scm_clk_if

// ---- pkg/scm_pkg.sv ----
// constants, register layout and state type of the system clock mode control
// assumes a 12-bit APB byte address and 32-bit data
package scm_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_CLK_MODE = 12'h000;
  localparam logic [11:0] ADDR_AUX_CTRL = 12'h004;
  localparam logic [11:0] ADDR_PWR_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
  // clock_mode_control fields
  localparam int CMC_DIV_LSB = 5;
  localparam int CMC_QWAKE_BIT = 4;
  localparam int CMC_SLOW_RDY_BIT = 3;
  localparam int CMC_FAST_RDY_BIT = 2;
  localparam int CMC_IDLE_SEL_BIT = 1;
  localparam int CMC_FAST_SEL_BIT = 0;
  localparam logic [7:0] CMC_RESET = 8'h03;
  localparam logic [7:0] CMC_WR_MASK = 8'hF3;
  // auxiliary control fields
  localparam int AUX_KEEP_ON_BIT = 0;
  localparam int AUX_WDT_ON_BIT = 1;
  localparam int AUX_LVD_ON_BIT = 2;
  localparam int AUX_FAST_TYPE_LSB = 4;
  localparam int AUX_SLOW_TYPE_BIT = 6;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] AUX_WR_MASK = 8'h77;
  // power status fields
  localparam int PWR_PDOWN_BIT = 0;
  localparam int PWR_WDT_EXP_BIT = 1;
  // fast oscillator type codes
  localparam logic [1:0] FAST_CRYSTAL = 2'h0;
  localparam logic [1:0] FAST_EXT_RC = 2'h1;
  localparam logic [1:0] FAST_EXT_CLOCK = 2'h2;
  localparam logic [1:0] FAST_INT_RC = 2'h3;
  // divider field codes
  localparam logic [2:0] DIV_SLOW_MAX = 3'h1;
  localparam logic [2:0] DIV_SHIFT_BASE = 3'h0;
  // interrupt status bits
  localparam int IRQ_FAST_RDY = 0;
  localparam int IRQ_SLOW_RDY = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_PDOWN = 3;
  localparam int IRQ_W = 4;
  // stability and wake counts, in oscillator cycles
  localparam int STAB_W = 11;
  localparam logic [STAB_W-1:0] FAST_XTAL_CYCLES = 11'h400;
  localparam logic [STAB_W-1:0] FAST_RC_CYCLES = 11'h010;
  localparam logic [STAB_W-1:0] SLOW_XTAL_CYCLES = 11'h400;
  localparam logic [STAB_W-1:0] SLOW_IRC_CYCLES = 11'h002;
  localparam logic [1:0] SUB_WAKE_CYCLES = 2'h2;
  localparam int PRESC_W = 6;

  typedef enum logic [2:0] {
    ST_RUN, ST_IDLE_RUN, ST_IDLE_STOP, ST_SLEEP_SUB, ST_SLEEP_DEEP,
    ST_WAKE, ST_WAKE_SUB_WAIT, ST_WAKE_SUB
  } scm_state_t;
endpackage : scm_pkg

// ---- src/scm_clk_sel.sv ----
// system clock selector: prescaler and source choice as clock-enable pulses
// assumes oscillator ticks are synchronised one-cycle pulses
`timescale 1ns/100ps
module scm_clk_sel
  import scm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // controller side
  scm_clk_if.sel cif
);
  logic [PRESC_W-1:0] presc_q;
  logic app_fast_q;
  logic [2:0] app_div_q;
  logic wrap;
  logic div_hit;
  logic [PRESC_W-1:0] low_mask;

  // fast divided by two to the power of (8 - code)
  function automatic logic [2:0] app_div_shift(input logic [2:0] code);
    app_div_shift = 3'h0 - code;
  endfunction : app_div_shift

  assign wrap = cif.fast_tick && (presc_q == {PRESC_W{1'b1}});
  assign low_mask = PRESC_W'((7'h01 << app_div_shift(app_div_q)) - 7'h01);
  assign div_hit = cif.fast_tick && ((presc_q & low_mask) == low_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= '0;
    end else if (ce) begin
      if (!cif.fast_on) begin
        presc_q <= '0;
      end else if (cif.fast_tick) begin
        presc_q <= presc_q + PRESC_W'(1);
      end
    end
  end

  // glitch-free switching
  // new selection applied only at a prescaler wrap or while fast is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      app_fast_q <= CMC_RESET[CMC_FAST_SEL_BIT];
      app_div_q <= CMC_RESET[CMC_DIV_LSB +: 3];
    end else if (ce && (wrap || !cif.fast_on)) begin
      app_fast_q <= cif.sel_fast;
      app_div_q <= cif.div;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.sys_tick <= 1'b0;
      cif.div16_tick <= 1'b0;
      cif.div64_tick <= 1'b0;
    end else if (ce) begin
      if (cif.force_sub) begin
        cif.sys_tick <= cif.slow_tick;
      end else if (app_fast_q) begin
        cif.sys_tick <= cif.fast_tick;
      end else if (app_div_q <= DIV_SLOW_MAX) begin
        cif.sys_tick <= cif.slow_tick;
      end else begin
        cif.sys_tick <= div_hit;
      end
      // peripheral fast taps stop with fast
      cif.div16_tick <= cif.fast_on && cif.fast_tick && (presc_q[3:0] == 4'hF);
      cif.div64_tick <= cif.fast_on && wrap;
    end
  end

endmodule : scm_clk_sel

// ---- src/scm_stab_cnt.sv ----
// oscillator stability counter: ready after target oscillator cycles
// assumes tick is a one-cycle pulse per oscillator cycle in pclk domain
`timescale 1ns/100ps
module scm_stab_cnt
  import scm_pkg::*;
#(
  parameter int W = STAB_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // oscillator
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] target,
  // status
  output logic ready
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_inc;

  assign cnt_inc = cnt_q + W'(1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      ready <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_q <= '0;
        ready <= 1'b0;
      end else if (tick && !ready) begin
        cnt_q <= cnt_inc;
        ready <= (cnt_inc >= target);
      end
    end
  end
endmodule : scm_stab_cnt

// ---- src/scm_top.sv ----
// system clock and low-power mode controller with APB registers
// assumes oscillators arrive as raw pins below half of pclk,
// and CPU halt, wake, watchdog time-out and clear requests are pclk pulses
//
// Behaviour
// - divider field picks slow or fast/64..fast/2
// - fast select bit gives undivided fast
// - quick wake uses substitute clock, crystal only
// - slow ready low in deep sleep, counted
// - fast ready cleared at power-on, then set
// - fast ready low while stopped, counted
// - idle select enters idle, keep-on picks kind
// - idle select low enters sleep
// - slow source stops fast oscillator and taps
// - quick wake: two sub cycles, then sub clock until crystal ready
// - quick wake only from substitute-on states
// - RC or clock sources ignore quick wake
// - watchdog, detector and idle select all off means no quick wake
// - deep sleep only with watchdog, detector off
// - stop sets power-down, clears expiry flag; a time-out in the same cycle sets it instead
`timescale 1ns/100ps
module scm_top
  import scm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator pins
  input wire logic fast_osc_pin,
  input wire logic slow_osc_pin,
  output logic fast_osc_on,
  output logic slow_osc_on,
  // cpu and watchdog events
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic wdt_timeout,
  input wire logic wdt_clear,
  // clock enables out
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic fast_div16_en,
  output logic fast_div64_en,
  // status
  output logic power_down_flag,
  output logic watchdog_expiry_flag,
  output logic irq
);
  scm_clk_if cif ();

  scm_state_t state_q;
  logic [7:0] cmc_q;
  logic [7:0] aux_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [1:0] sub_cnt_q;
  logic [2:0] sync_q [2];
  logic fast_rdy;
  logic slow_rdy;
  logic fast_rdy_q;
  logic slow_rdy_q;
  logic fast_on_d;
  logic src_fast;
  logic quick_ok;
  logic wake_done;
  logic enter_pd;
  logic wr_en;
  logic rd_setup;
  logic [IRQ_W-1:0] irq_evt;
  logic [2:0] div_f;
  logic [1:0] fast_type;
  logic [STAB_W-1:0] fast_target;
  logic [STAB_W-1:0] slow_target;

  assign div_f = cmc_q[CMC_DIV_LSB +: 3];
  assign fast_type = aux_q[AUX_FAST_TYPE_LSB +: 2];
  assign src_fast = cmc_q[CMC_FAST_SEL_BIT] || (div_f > DIV_SLOW_MAX);

  // two-stage synchronisers, third stage for edge detection
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync_q[i] <= 3'h0;
      end else if (ce) begin
        sync_q[i] <= {sync_q[i][1:0], (i == 0) ? fast_osc_pin : slow_osc_pin};
      end
    end
  end

  assign cif.fast_tick = sync_q[0][1] && !sync_q[0][2];
  assign cif.slow_tick = sync_q[1][1] && !sync_q[1][2];
  assign cif.fast_on = fast_osc_on;
  assign cif.sel_fast = cmc_q[CMC_FAST_SEL_BIT];
  assign cif.div = div_f;
  assign cif.force_sub = (state_q == ST_WAKE_SUB);

  scm_clk_sel u_clk_sel (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .cif(cif)
  );

  // crystal counts 1024, RC and clock 16
  assign fast_target = (fast_type == FAST_CRYSTAL) ? FAST_XTAL_CYCLES : FAST_RC_CYCLES;
  // crystal counts 1024, internal RC 2
  assign slow_target = aux_q[AUX_SLOW_TYPE_BIT] ? SLOW_IRC_CYCLES : SLOW_XTAL_CYCLES;

  // counter restarts from zero when fast powers up
  scm_stab_cnt #(.W(STAB_W)) u_fast_stab (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(fast_osc_on),
    .tick(cif.fast_tick),
    .target(fast_target),
    .ready(fast_rdy)
  );

  scm_stab_cnt #(.W(STAB_W)) u_slow_stab (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(slow_osc_on),
    .tick(cif.slow_tick),
    .target(slow_target),
    .ready(slow_rdy)
  );

  // quick wake needs crystal and fast source
  // RC or clock sources never take it
  assign quick_ok = cmc_q[CMC_QWAKE_BIT] && (fast_type == FAST_CRYSTAL) && src_fast
                    && (aux_q[AUX_WDT_ON_BIT] || aux_q[AUX_LVD_ON_BIT] ||
                        cmc_q[CMC_IDLE_SEL_BIT]);
  assign enter_pd = (state_q == ST_RUN) && halt_req;

  // mode state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_WAKE;
      sub_cnt_q <= 2'h0;
    end else if (ce) begin
      unique case (state_q)
        ST_RUN: begin
          if (halt_req) begin
            if (cmc_q[CMC_IDLE_SEL_BIT]) begin
              state_q <= aux_q[AUX_KEEP_ON_BIT] ? ST_IDLE_RUN : ST_IDLE_STOP;
            end else if (aux_q[AUX_WDT_ON_BIT] || aux_q[AUX_LVD_ON_BIT]) begin
              state_q <= ST_SLEEP_SUB;
            end else begin
              state_q <= ST_SLEEP_DEEP;
            end
          end
        end
        ST_IDLE_RUN: begin
          if (wake_req) begin
            state_q <= ST_RUN;
          end
        end
        ST_IDLE_STOP, ST_SLEEP_SUB: begin
          // quick wake only from these states
          if (wake_req) begin
            state_q <= quick_ok ? ST_WAKE_SUB_WAIT : ST_WAKE;
            sub_cnt_q <= 2'h0;
          end
        end
        ST_SLEEP_DEEP: begin
          if (wake_req) begin
            state_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (src_fast ? fast_rdy : slow_rdy) begin
            state_q <= ST_RUN;
          end
        end
        ST_WAKE_SUB_WAIT: begin
          if (cif.slow_tick) begin
            sub_cnt_q <= sub_cnt_q + 2'h1;
            if (sub_cnt_q + 2'h1 >= SUB_WAKE_CYCLES) begin
              state_q <= ST_WAKE_SUB;
            end
          end
        end
        ST_WAKE_SUB: begin
          // hand over to crystal once ready
          if (fast_rdy) begin
            state_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  assign wake_done = ((state_q == ST_WAKE) && (src_fast ? fast_rdy : slow_rdy)) ||
                     ((state_q == ST_WAKE_SUB) && fast_rdy) ||
                     ((state_q == ST_IDLE_RUN) && wake_req);

  // fast off in sleep and stopped idle
  always_comb begin
    fast_on_d = 1'b0;
    unique case (state_q)
      ST_RUN, ST_IDLE_RUN, ST_WAKE: fast_on_d = src_fast;
      ST_WAKE_SUB_WAIT, ST_WAKE_SUB: fast_on_d = 1'b1;
      ST_IDLE_STOP, ST_SLEEP_SUB, ST_SLEEP_DEEP: fast_on_d = 1'b0;
    endcase
  end

  // slow off only in deep sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_on <= 1'b1;
      slow_osc_on <= 1'b1;
    end else if (ce) begin
      fast_osc_on <= fast_on_d;
      slow_osc_on <= (state_q != ST_SLEEP_DEEP) && !(enter_pd &&
                     !cmc_q[CMC_IDLE_SEL_BIT] && !aux_q[AUX_WDT_ON_BIT] &&
                     !aux_q[AUX_LVD_ON_BIT]);
    end
  end

  // cpu stops in idle, system clock only in running idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b0;
      sys_clk_en <= 1'b0;
      fast_div16_en <= 1'b0;
      fast_div64_en <= 1'b0;
    end else if (ce) begin
      cpu_clk_en <= cif.sys_tick && ((state_q == ST_RUN) || (state_q == ST_WAKE_SUB));
      sys_clk_en <= cif.sys_tick && ((state_q == ST_RUN) || (state_q == ST_WAKE_SUB) ||
                                     (state_q == ST_IDLE_RUN));
      fast_div16_en <= cif.div16_tick;
      fast_div64_en <= cif.div64_tick;
    end
  end

  // power-down set, expiry cleared on stop; a time-out in the same cycle sets expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_flag <= 1'b0;
      watchdog_expiry_flag <= 1'b0;
    end else if (ce) begin
      if (enter_pd) begin
        power_down_flag <= 1'b1;
      end else if (wdt_clear) begin
        power_down_flag <= 1'b0;
      end
      if (wdt_timeout) begin
        watchdog_expiry_flag <= 1'b1;
      end else if (enter_pd) begin
        watchdog_expiry_flag <= 1'b0;
      end
    end
  end

  // apb: always ready, read data captured in the setup cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // ready bits masked out of writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmc_q <= CMC_RESET;
      aux_q <= AUX_RESET;
      irq_mask_q <= '0;
    end else if (ce && wr_en) begin
      if (paddr == ADDR_CLK_MODE) begin
        cmc_q <= pwdata[7:0] & CMC_WR_MASK;
      end
      if (paddr == ADDR_AUX_CTRL) begin
        aux_q <= pwdata[7:0] & AUX_WR_MASK;
      end
      if (paddr == ADDR_IRQ_MASK) begin
        irq_mask_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_rdy_q <= 1'b0;
      slow_rdy_q <= 1'b0;
    end else if (ce) begin
      fast_rdy_q <= fast_rdy;
      slow_rdy_q <= slow_rdy;
    end
  end

  assign irq_evt[IRQ_FAST_RDY] = fast_rdy && !fast_rdy_q;
  assign irq_evt[IRQ_SLOW_RDY] = slow_rdy && !slow_rdy_q;
  assign irq_evt[IRQ_WAKE] = wake_done;
  assign irq_evt[IRQ_PDOWN] = enter_pd;

  // sticky status, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat_q <= (irq_stat_q & ~((wr_en && (paddr == ADDR_IRQ_STAT)) ?
                    pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | irq_evt;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && rd_setup) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      unique case (paddr)
        ADDR_CLK_MODE: prdata[7:0] <= {cmc_q[7:4], slow_rdy, fast_rdy, cmc_q[1:0]};
        ADDR_AUX_CTRL: prdata[7:0] <= aux_q;
        ADDR_PWR_STAT: prdata[1:0] <= {watchdog_expiry_flag, power_down_flag};
        ADDR_IRQ_STAT: prdata[IRQ_W-1:0] <= irq_stat_q;
        ADDR_IRQ_MASK: prdata[IRQ_W-1:0] <= irq_mask_q;
        default: pslverr <= 1'b1;
      endcase
    end
  end
endmodule : scm_top

// ---- tb/scm_monitor.sv ----
// port checker of the clock mode controller
// assumes it is bound into scm_top
`timescale 1ns/100ps
module scm_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  // events
  input wire logic halt_req,
  input wire logic wdt_timeout,
  input wire logic wdt_clear,
  // clocks and status
  input wire logic fast_osc_on,
  input wire logic slow_osc_on,
  input wire logic cpu_clk_en,
  input wire logic sys_clk_en,
  input wire logic fast_div16_en,
  input wire logic fast_div64_en,
  input wire logic power_down_flag,
  input wire logic watchdog_expiry_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_all_off;
    (!fast_osc_on && !slow_osc_on) [*8];
  endsequence
  sequence s_fast_off;
    (!fast_osc_on) [*8];
  endsequence
  unmapped_err_a: assert property (psel && !penable && paddr[1:0] == 2'b00
    |=> pslverr == ($past(paddr) > 12'h010)) else $error("wrong slave error");
  pdown_cause_a: assert property ($rose(power_down_flag) |-> $past(halt_req))
    else $error("power-down flag set without halt");
  expiry_clear_a: assert property ($rose(power_down_flag) && !$past(wdt_timeout)
    |-> !watchdog_expiry_flag) else $error("expiry flag kept on halt");
  expiry_set_a: assert property (wdt_timeout |=> watchdog_expiry_flag)
    else $error("expiry flag not set");
  pdown_clear_a: assert property (wdt_clear && !halt_req |=> !power_down_flag)
    else $error("power-down flag not cleared");
  slow_stop_a: assert property ($fell(slow_osc_on) |-> $past(halt_req))
    else $error("slow osc stopped without halt");
  deep_quiet_a: assert property (s_all_off |-> !cpu_clk_en && !sys_clk_en)
    else $error("clock pulse with both osc off");
  tap_stop_a: assert property (s_fast_off |-> !fast_div16_en && !fast_div64_en)
    else $error("fast taps run while fast osc off");
  tap_gap_a: assert property (fast_div16_en |=> (!fast_div16_en) [*8])
    else $error("fast div16 tap too fast");
endmodule : scm_monitor
bind scm_top scm_monitor u_mon (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
  .halt_req, .wdt_timeout, .wdt_clear, .fast_osc_on, .slow_osc_on, .cpu_clk_en,
  .sys_clk_en, .fast_div16_en, .fast_div64_en, .power_down_flag, .watchdog_expiry_flag);

// ---- tb/scm_osc_model.sv ----
// fast and slow oscillators feeding the raw clock pins of scm_top
// assumes the power enables of scm_top; a stopped oscillator holds its pin low
`timescale 1ns/100ps
module scm_osc_model #(
  parameter int FAST_HALF = 4,
  parameter int SLOW_HALF = 6
) (
  // clock
  input wire logic pclk,
  // power enables
  input wire logic fast_on,
  input wire logic slow_on,
  // pins
  output logic fast_pin,
  output logic slow_pin
);
  int fcnt = 0;
  int scnt = 0;
  initial begin
    fast_pin = 1'b0;
    slow_pin = 1'b0;
  end
  always @(posedge pclk) begin
    fcnt <= (!fast_on || fcnt == FAST_HALF - 1) ? 0 : fcnt + 1;
    fast_pin <= !fast_on ? 1'b0 : (fcnt == FAST_HALF - 1) ? !fast_pin : fast_pin;
    scnt <= (!slow_on || scnt == SLOW_HALF - 1) ? 0 : scnt + 1;
    slow_pin <= !slow_on ? 1'b0 : (scnt == SLOW_HALF - 1) ? !slow_pin : slow_pin;
  end
endmodule : scm_osc_model

// ---- tb/system_clock_mode_control_tb_top.sv ----
// self-checking bench of scm_top with an oscillator model
// assumes fast osc period 8 pclk, slow osc period 12 pclk
`timescale 1ns/100ps
module system_clock_mode_control_tb_top;
  import scm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, halt_req, wake_req, wdt_timeout, wdt_clear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, fast_osc_pin, slow_osc_pin, fast_osc_on, slow_osc_on;
  logic cpu_clk_en, sys_clk_en, fast_div16_en, fast_div64_en;
  logic power_down_flag, watchdog_expiry_flag, irq;
  int errors = 0;
  int tests_run = 0;
  int nc, ns, p;
  always #12.5 pclk = !pclk;
  scm_top u_dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fast_osc_pin, .slow_osc_pin, .fast_osc_on, .slow_osc_on,
    .halt_req, .wake_req, .wdt_timeout, .wdt_clear, .cpu_clk_en, .sys_clk_en,
    .fast_div16_en, .fast_div64_en, .power_down_flag, .watchdog_expiry_flag, .irq);
  scm_osc_model u_osc (.pclk, .fast_on(fast_osc_on), .slow_on(slow_osc_on),
    .fast_pin(fast_osc_pin), .slow_pin(slow_osc_pin));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic ev(input int k);
    {wdt_clear, wdt_timeout, wake_req, halt_req} <= 4'b0001 << k;
    @(posedge pclk);
    {wdt_clear, wdt_timeout, wake_req, halt_req} <= 4'h0;
    @(posedge pclk);
  endtask : ev
  task automatic cnt(input int cyc);
    nc = 0;
    ns = 0;
    repeat (cyc) begin
      @(posedge pclk);
      nc += int'(cpu_clk_en === 1'b1);
      ns += int'(sys_clk_en === 1'b1);
    end
  endtask : cnt
  task automatic per();
    int n;
    n = 0;
    while (sys_clk_en !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    p = 0;
    do begin
      @(posedge pclk);
      p++;
    end while (sys_clk_en !== 1'b1 && p < 2000);
  endtask : per
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_CLK_MODE, 32'h0000_0000);
      n++;
    end while (rd[3:2] !== 2'b11 && n < 9000);
    chk("ready flags", 32'h0000_0003, rd[3:2]);
  endtask : wait_rdy
  // new divider is in use after the second fast/64 tap
  task automatic wrap2();
    int n;
    n = 0;
    repeat (2) begin
      do begin
        @(posedge pclk);
        n++;
      end while (fast_div64_en !== 1'b1 && n < 2000);
    end
  endtask : wrap2
  task automatic t_boot();
    apb(1'b0, ADDR_CLK_MODE, 32'h0000_0000);
    chk("mode reset", 32'h0000_0003, rd & 32'h0000_00F3);
    chk("fast ready at power-on", 32'h0000_0000, rd[2]);
    wait_rdy();
    apb(1'b1, ADDR_CLK_MODE, 32'h0000_0003);
    apb(1'b0, ADDR_CLK_MODE, 32'h0000_0000);
    chk("ready not writable", 32'h0000_000F, rd);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, err);
    chk("unmapped data", 32'h0000_0000, rd);
    chk("irq masked", 32'h0000_0000, irq);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    cnt(2);
    chk("irq raised", 32'h0000_0001, irq);
    apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0001);
    cnt(2);
    chk("irq cleared", 32'h0000_0000, irq);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
  endtask : t_boot
  task automatic t_div();
    apb(1'b1, ADDR_CLK_MODE, 32'h0000_0003);
    per();
    per();
    chk("fast period", 32'd8, p);
    for (int c = 7; c >= 0; c--) begin
      apb(1'b1, ADDR_CLK_MODE, (c << CMC_DIV_LSB) | 32'h0000_0002);
      if (c >= 2) begin
        wrap2();
      end
      per();
      per();
      chk("div period", (c < 2) ? 32'd12 : 32'd1 << (11 - c), p);
    end
    chk("fast osc off on slow", 32'h0000_0000, fast_osc_on);
    apb(1'b1, ADDR_CLK_MODE, 32'h0000_0003);
    wait_rdy();
  endtask : t_div
  task automatic t_sleep();
    apb(1'b1, ADDR_AUX_CTRL, 32'h0000_0040);
    apb(1'b1, ADDR_CLK_MODE, 32'h0000_0011);
    ev(2);
    chk("expiry set", 32'h0000_0001, watchdog_expiry_flag);
    ev(0);
    chk("pdown flag", 32'h0000_0001, power_down_flag);
    chk("expiry cleared", 32'h0000_0000, watchdog_expiry_flag);
    chk("deep sleep slow off", 32'h0000_0000, slow_osc_on);
    cnt(50);
    chk("deep sleep fast off", 32'h0000_0000, fast_osc_on);
    chk("deep sleep pulses", 32'h0000_0000, nc + ns);
    apb(1'b0, ADDR_PWR_STAT, 32'h0000_0000);
    chk("pdown read", 32'h0000_0001, rd);
    ev(1);
    cnt(40);
    chk("deep wake no quick", 32'h0000_0000, nc);
    apb(1'b0, ADDR_CLK_MODE, 32'h0000_0000);
    chk("slow ready first", 32'h0000_0002, rd[3:2]);
    wait_rdy();
    cnt(20);
    chk("cpu runs after wake", 32'h0000_0001, nc > 0);
    ev(3);
    chk("pdown clear", 32'h0000_0000, power_down_flag);
  endtask : t_sleep
  task automatic t_idle(input logic [31:0] aux);
    apb(1'b1, ADDR_AUX_CTRL, aux);
    apb(1'b1, ADDR_CLK_MODE, 32'h0000_0003);
    ev(0);
    cnt(100);
    chk("idle cpu", 32'h0000_0000, nc);
    chk("idle sys clock", {31'h0, aux[0]}, ns > 0);
    apb(1'b0, ADDR_CLK_MODE, 32'h0000_0000);
    chk("idle fast ready", {31'h0, aux[0]}, rd[2]);
    ev(1);
    wait_rdy();
  endtask : t_idle
  task automatic t_quick(input logic [31:0] aux, input logic quick);
    apb(1'b1, ADDR_AUX_CTRL, aux);
    apb(1'b1, ADDR_CLK_MODE, 32'h0000_0011);
    ev(0);
    chk("sub clock kept", 32'h0000_0001, slow_osc_on);
    ev(1);
    cnt(60);
    chk("quick wake cpu", {31'h0, quick}, nc > 0);
    apb(1'b0, ADDR_CLK_MODE, 32'h0000_0000);
    chk("fast ready in quick", 32'h0000_0000, quick & rd[2]);
    wait_rdy();
  endtask : t_quick
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    {psel, penable, pwrite, halt_req, wake_req, wdt_timeout, wdt_clear} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_boot();
    t_div();
    t_sleep();
    t_idle(32'h0000_0001);
    t_idle(32'h0000_0020);
    t_quick(32'h0000_0004, 1'b1);
    t_quick(32'h0000_0052, 1'b0);
    print_verdict();
  end
  initial begin
    #2_500_000;
    errors++;
    print_verdict();
  end
endmodule : system_clock_mode_control_tb_top
